// *** ucc_pkg.sv ***
// Package of constants for the USB device core control block
package ucc_pkg;
  localparam int NUM_EP = 7;
  localparam int DPRAM_BYTES = 832;
  localparam int EP0_MAX = 64;
  localparam int EP1_MAX = 256;
  localparam int EPN_MAX = 64;
  localparam int ADDR_W = 10;
  localparam int REF_CLK_HZ = 48000000;
  localparam int FS_BIT_HZ = 12000000;
  localparam int LS_BIT_HZ = 1500000;
  localparam int FS_DIV = REF_CLK_HZ / FS_BIT_HZ;
  localparam int LS_DIV = REF_CLK_HZ / LS_BIT_HZ;
  localparam int REF_PPM_TOL = 2500;
  localparam int SIZE_W = 3;
  localparam int BASE_BYTES = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 8;
  typedef enum logic [1:0] {
    UCC_RESET = 2'b00,
    UCC_IDLE = 2'b01,
    UCC_RUN = 2'b11,
    UCC_FROZEN = 2'b10
  } ucc_state_e;
endpackage

// *** ucc_core.sv ***
// USB device core control: enable, clocks, interrupts, buffer allocation
`timescale 1ns/1ns
`default_nettype none
// Function
// - 832-byte buffer memory, seven endpoints sized.
// - Full speed needs 48MHz PLL reference.
// - Derive 12MHz or 1.5MHz bit clock.
// - RC source allowed only at low speed.
// - Any hardware reset disables and resets.
// - End-of-reset CPU reset keeps controller enabled.
// - Reset state: frozen, disabled, pad suspended.
// - Enable enters idle; clearing acts as reset.
// - Separate general and endpoint interrupt requests.
// - Only VBUS and wakeup detected asynchronously.
// - Eight enabled flag sources per endpoint.
// - Readable per-endpoint interrupt summary.
// - Power-down wakeup via wakeup and VBUS flags.
// - Control registers stay accessible while frozen.
// - Frozen: only wakeup and VBUS flags set.
// - Low-speed select picks D- pull-up.
// - Reserve inserts buffer; next one slides up.
// - Disable keeps reserve; free slides next down.
// - Endpoint 0 data survives higher endpoint changes.
// - Same-parameter reactivation does not shift others.
// - Config accepted set even on overlap.
// - Disable also stops transceiver and clocks.
// - Freeze gates clocks, keeps resume detection.

module ucc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic clkEn,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_reg;
  logic [AW:0] rdPtr_reg;
  wire logic full;
  wire logic empty;
  wire logic doWr;
  wire logic doRd;
  assign empty = wrPtr_reg == rdPtr_reg;
  assign full = (wrPtr_reg[AW] != rdPtr_reg[AW]) &&
                (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
  assign inReady = !full;
  assign outValid = !empty;
  assign doWr = clkEn && inValid && !full;
  assign doRd = clkEn && outReady && !empty;
  assign outData = mem[rdPtr_reg[AW-1:0]];
  always_ff @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr_reg[AW-1:0]] <= inData;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      if (doWr) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (doRd) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
    end
  end
endmodule

module ucc_core #(
  parameter int NEP = ucc_pkg::NUM_EP
) (
  input wire logic clk,
  input wire logic clkEn,
  input wire logic sys_rst,
  input wire logic usbEndReset,
  input wire logic cpuResetOnEor,
  input wire logic macroEnable,
  input wire logic freezeClockBit,
  input wire logic lowSpeedSelect,
  input wire logic pllSourceRc,
  input wire logic pllLocked,
  input wire logic vbusPin,
  input wire logic dataLineP,
  input wire logic dataLineM,
  input wire logic wakeupFlagClr,
  input wire logic vbusTransitionFlagClr,
  input wire logic wakeupIntEn,
  input wire logic vbusIntEn,
  input wire logic [NEP-1:0] endpointEnableBit,
  input wire logic [NEP-1:0] memoryReserveBit,
  input wire logic [NEP*ucc_pkg::SIZE_W-1:0] endpointSizeField,
  input wire logic [NEP-1:0] endpointBankCount,
  input wire logic [NEP*8-1:0] epFlagSet,
  input wire logic [NEP*8-1:0] epFlagClr,
  input wire logic [NEP*8-1:0] epFlagEn,
  input wire logic [7:0] rxByte,
  input wire logic rxValid,
  output logic rxReady,
  output logic [7:0] bufByte,
  output logic bufValid,
  input wire logic bufReady,
  output logic [1:0] ctrlState,
  output logic controllerClkGate,
  output logic transceiverEnable,
  output logic padSuspend,
  output logic pullUpDp,
  output logic pullUpDm,
  output logic bitClkTick,
  output logic speedFault,
  output logic cpuResetReq,
  output logic wakeupFlag,
  output logic vbusTransitionFlag,
  output logic vbusStatus,
  output logic generalIrq,
  output logic endpointIrq,
  output logic [NEP-1:0] endpointIntSummary,
  output logic [NEP*8-1:0] epFlags,
  output logic [NEP-1:0] configAcceptedFlag,
  output logic [NEP*ucc_pkg::ADDR_W-1:0] epBase,
  output logic [NEP-1:0] epDataLost
);
  localparam int AW = ucc_pkg::ADDR_W;
  localparam int SW = ucc_pkg::SIZE_W;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] vbusSync_reg;
  logic [2:0] dpSync_reg;
  logic [2:0] dmSync_reg;
  logic vbusStable_reg;
  logic [1:0] lineStable_reg;
  wire logic vbusAgree;
  wire logic lineAgree;
  wire logic vbusChange;
  wire logic lineChange;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vbusSync_reg <= 3'h0;
      dpSync_reg <= 3'h7;
      dmSync_reg <= 3'h0;
    end else if (clkEn) begin
      vbusSync_reg <= {vbusSync_reg[1:0], vbusPin};
      dpSync_reg <= {dpSync_reg[1:0], dataLineP};
      dmSync_reg <= {dmSync_reg[1:0], dataLineM};
    end
  end
  assign vbusAgree = vbusSync_reg[1] == vbusSync_reg[2];
  assign lineAgree = (dpSync_reg[1] == dpSync_reg[2]) &&
                     (dmSync_reg[1] == dmSync_reg[2]);
  assign vbusChange = vbusAgree && (vbusSync_reg[2] != vbusStable_reg);
  assign lineChange = lineAgree &&
                      ({dpSync_reg[2], dmSync_reg[2]} != lineStable_reg);

  // ---------------------------------------------------------------
  // Controller state
  // ---------------------------------------------------------------
  ucc_pkg::ucc_state_e state_reg;
  ucc_pkg::ucc_state_e state_next;
  wire logic ctrlReset;
  wire logic running;
  assign ctrlReset = !macroEnable;
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ucc_pkg::UCC_RESET: begin
        if (macroEnable) begin
          state_next = ucc_pkg::UCC_IDLE;
        end
      end
      ucc_pkg::UCC_IDLE: begin
        if (!freezeClockBit && pllLocked) begin
          state_next = ucc_pkg::UCC_RUN;
        end
      end
      ucc_pkg::UCC_RUN: begin
        if (freezeClockBit) begin
          state_next = ucc_pkg::UCC_FROZEN;
        end
      end
      ucc_pkg::UCC_FROZEN: begin
        if (!freezeClockBit) begin
          state_next = ucc_pkg::UCC_RUN;
        end
      end
    endcase
    if (ctrlReset) begin
      state_next = ucc_pkg::UCC_RESET;
    end
  end
  // End-of-reset CPU reset leaves the state untouched
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= ucc_pkg::UCC_RESET;
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end
  assign ctrlState = state_reg;
  assign running = state_reg == ucc_pkg::UCC_RUN;
  assign cpuResetReq = usbEndReset && cpuResetOnEor &&
                       macroEnable;
  assign controllerClkGate = running;
  assign transceiverEnable = state_reg != ucc_pkg::UCC_RESET;
  assign padSuspend = !running;
  assign pullUpDm = transceiverEnable && lowSpeedSelect;
  assign pullUpDp = transceiverEnable && !lowSpeedSelect;
  assign speedFault = running && pllSourceRc && !lowSpeedSelect;

  // ---------------------------------------------------------------
  // Bit clock from the 48 MHz reference
  // ---------------------------------------------------------------
  logic [5:0] bitDiv_reg;
  logic dpllLast_reg;
  wire logic [5:0] divLast;
  assign divLast = lowSpeedSelect ? 6'(ucc_pkg::LS_DIV - 1)
                                  : 6'(ucc_pkg::FS_DIV - 1);
  // Edge on the received line realigns the phase
  always_ff @(posedge clk) begin
    if (sys_rst || ctrlReset) begin
      bitDiv_reg <= 6'h00;
      dpllLast_reg <= 1'b0;
    end else if (clkEn && running) begin
      dpllLast_reg <= dpSync_reg[2];
      if (dpllLast_reg != dpSync_reg[2] || bitDiv_reg >= divLast) begin
        bitDiv_reg <= 6'h00;
      end else begin
        bitDiv_reg <= bitDiv_reg + 6'h01;
      end
    end
  end
  assign bitClkTick = running && (bitDiv_reg == (divLast >> 1));

  // ---------------------------------------------------------------
  // General flags
  // ---------------------------------------------------------------
  logic wakeup_reg;
  logic vbusTr_reg;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wakeup_reg <= 1'b0;
      vbusTr_reg <= 1'b0;
      vbusStable_reg <= 1'b0;
      lineStable_reg <= 2'b10;
    end else if (clkEn) begin
      if (vbusAgree) begin
        vbusStable_reg <= vbusSync_reg[2];
      end
      if (lineAgree) begin
        lineStable_reg <= {dpSync_reg[2], dmSync_reg[2]};
      end
      // Set beats clear; VBUS set works in any state, wakeup set only while macroEnable is high
      if (vbusChange) begin
        vbusTr_reg <= 1'b1;
      end else if (vbusTransitionFlagClr) begin
        vbusTr_reg <= 1'b0;
      end
      if (lineChange && macroEnable) begin
        wakeup_reg <= 1'b1;
      end else if (wakeupFlagClr || ctrlReset) begin
        wakeup_reg <= 1'b0;
      end
    end
  end
  assign wakeupFlag = wakeup_reg;
  assign vbusTransitionFlag = vbusTr_reg;
  assign vbusStatus = vbusStable_reg;
  assign generalIrq = (wakeup_reg && wakeupIntEn) ||
                      (vbusTr_reg && vbusIntEn);

  // ---------------------------------------------------------------
  // Endpoint flags, set only while the clock runs; clear works in any state
  // ---------------------------------------------------------------
  logic [NEP*8-1:0] epFlags_reg;
  genvar g;
  generate
    for (g = 0; g < NEP*8; g++) begin : gFlag
      always_ff @(posedge clk) begin
        if (sys_rst || ctrlReset) begin
          epFlags_reg[g] <= 1'b0;
        end else if (clkEn) begin
          if (epFlagSet[g] && running) begin
            epFlags_reg[g] <= 1'b1;
          end else if (epFlagClr[g]) begin
            epFlags_reg[g] <= 1'b0;
          end
        end
      end
    end
    for (g = 0; g < NEP; g++) begin : gSum
      assign endpointIntSummary[g] =
        |(epFlags_reg[g*8 +: 8] & epFlagEn[g*8 +: 8]);
    end
  endgenerate
  assign epFlags = epFlags_reg;
  assign endpointIrq = |endpointIntSummary;

  // ---------------------------------------------------------------
  // Buffer allocation in the 832-byte memory
  // ---------------------------------------------------------------
  logic [NEP-1:0] resvPrev_reg;
  logic [NEP*AW-1:0] base_reg;
  logic [NEP*AW-1:0] len_reg;
  logic [NEP-1:0] config_accepted_flag_reg;
  logic [NEP-1:0] lost_reg;
  logic [NEP*AW-1:0] reqLen;
  logic [NEP*AW-1:0] endAddr;
  logic [NEP*AW+AW-1:0] slotBase;
  always_comb begin
    slotBase = '0;
    for (int i = 0; i < NEP; i++) begin
      reqLen[i*AW +: AW] = AW'((ucc_pkg::BASE_BYTES <<
        endpointSizeField[i*SW +: SW]) << endpointBankCount[i]);
      endAddr[i*AW +: AW] = (memoryReserveBit[i] && !resvPrev_reg[i]) ?
        slotBase[i*AW +: AW] + reqLen[i*AW +: AW] :
        base_reg[i*AW +: AW] + len_reg[i*AW +: AW];
      slotBase[i*AW+AW +: AW] = memoryReserveBit[i] ?
        endAddr[i*AW +: AW] : base_reg[i*AW +: AW];
    end
  end
  generate
    for (g = 0; g < NEP; g++) begin : gAlloc
      localparam int MAXB = (g == 0) ? ucc_pkg::EP0_MAX :
        ((g == 1) ? ucc_pkg::EP1_MAX : ucc_pkg::EPN_MAX);
      wire logic rise;
      wire logic fall;
      wire logic prevMove;
      wire logic fits;
      wire logic [AW-1:0] newBase;
      assign rise = memoryReserveBit[g] && !resvPrev_reg[g];
      assign fall = !memoryReserveBit[g] && resvPrev_reg[g];
      if (g == 0) begin : gFirst
        assign newBase = '0;
        assign prevMove = 1'b0;
      end else begin : gNext
        assign newBase = slotBase[g*AW +: AW];
        // Only a change directly below moves this buffer
        assign prevMove = (memoryReserveBit[g-1] != resvPrev_reg[g-1]) &&
          (reqLen[(g-1)*AW +: AW] != len_reg[(g-1)*AW +: AW] ||
           memoryReserveBit[g-1] == 1'b0 || !resvPrev_reg[g-1]);
      end
      assign fits = (reqLen[g*AW +: AW] >> endpointBankCount[g]) <=
                    AW'(MAXB) &&
                    (32'(newBase) + 32'(reqLen[g*AW +: AW])) <=
                    ucc_pkg::DPRAM_BYTES;
      always_ff @(posedge clk) begin
        if (sys_rst || ctrlReset) begin
          resvPrev_reg[g] <= 1'b0;
          base_reg[g*AW +: AW] <= '0;
          len_reg[g*AW +: AW] <= '0;
          config_accepted_flag_reg[g] <= 1'b0;
          lost_reg[g] <= 1'b0;
        end else if (clkEn) begin
          resvPrev_reg[g] <= memoryReserveBit[g];
          if (rise) begin
            base_reg[g*AW +: AW] <= newBase;
            len_reg[g*AW +: AW] <= reqLen[g*AW +: AW];
            config_accepted_flag_reg[g] <= fits;
            lost_reg[g] <= 1'b0;
          end else if (fall) begin
            len_reg[g*AW +: AW] <= '0;
            config_accepted_flag_reg[g] <= 1'b0;
          end else if (prevMove && memoryReserveBit[g]) begin
            base_reg[g*AW +: AW] <= newBase;
            lost_reg[g] <= 1'b1;
          end
          if (!endpointEnableBit[g] && g == 0) begin
            lost_reg[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate
  assign configAcceptedFlag = config_accepted_flag_reg;
  assign epBase = base_reg;
  assign epDataLost = lost_reg;

  // ---------------------------------------------------------------
  // Receive data buffer
  // ---------------------------------------------------------------
  wire logic fifoInValid;
  wire logic fifoInReady;
  assign fifoInValid = rxValid && running;
  assign rxReady = fifoInReady && running;
  ucc_fifo #(
    .WIDTH(ucc_pkg::FIFO_WIDTH),
    .DEPTH(ucc_pkg::FIFO_DEPTH)
  ) uFifo (
    .clk(clk),
    .clkEn(clkEn),
    .sys_rst(sys_rst || ctrlReset),
    .inData(rxByte),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .outData(bufByte),
    .outValid(bufValid),
    .outReady(bufReady)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  disabled_resets_a: assert property (@(posedge clk) disable iff (sys_rst)
    clkEn && !macroEnable |=> state_reg == ucc_pkg::UCC_RESET)
    else $error("disable did not reset controller");
  enable_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    clkEn && macroEnable && state_reg == ucc_pkg::UCC_RESET
    |=> state_reg == ucc_pkg::UCC_IDLE)
    else $error("enable did not reach idle");
  frozen_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_reg == ucc_pkg::UCC_FROZEN |-> !controllerClkGate &&
    transceiverEnable)
    else $error("frozen clock gate wrong");
  pullup_pick_a: assert property (@(posedge clk) disable iff (sys_rst)
    transceiverEnable |-> pullUpDm == lowSpeedSelect &&
    pullUpDp != lowSpeedSelect)
    else $error("pull-up choice wrong");
  frozen_ep_a: assert property (@(posedge clk) disable iff (sys_rst)
    !running ##1 !running |-> !($rose(epFlags_reg[0])))
    else $error("endpoint flag set while frozen");
  vbus_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
    clkEn && vbusChange |=> vbusTr_reg)
    else $error("vbus transition lost");
  ep_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
    endpointIrq == |(epFlags_reg & epFlagEn))
    else $error("endpoint request mismatch");
  ep0_data_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(lost_reg[0]) |-> !$past(endpointEnableBit[0]))
    else $error("endpoint 0 data lost");
  wire logic rise_0;
  wire logic fits_0;
  assign rise_0 = gAlloc[0].rise;
  assign fits_0 = gAlloc[0].fits;
  cfg_ok_a: assert property (@(posedge clk) disable iff (sys_rst)
    clkEn && !ctrlReset && rise_0 |=> config_accepted_flag_reg[0] == $past(fits_0))
    else $error("config accepted wrong");
endmodule
`default_nettype wire

// *** ucc_host_model.sv ***
// Host-side partner: bus pins and received byte stream into the core
`timescale 1ns/1ns
`default_nettype none
module ucc_host_model (
  input wire logic clk,
  input wire logic rxReady,
  input wire logic stall,
  output logic [7:0] rxByte,
  output logic rxValid,
  output logic bufReady,
  output logic vbusPin,
  output logic dataLineP,
  output logic dataLineM
);
  // -----------------------------------------------------------
  // Idle bus: J state on the data lines, cable unplugged
  // -----------------------------------------------------------
  initial begin
    rxByte = 8'h00;
    rxValid = 1'b0;
    vbusPin = 1'b0;
    dataLineP = 1'b1;
    dataLineM = 1'b0;
  end
  assign bufReady = ~stall;
  // -----------------------------------------------------------
  // Byte offer, called just after an edge; held until taken or four edges pass
  // -----------------------------------------------------------
  task automatic send(input logic [7:0] b, output bit ok);
    ok = 1'b0;
    rxByte = b;
    rxValid = 1'b1;
    repeat (4) begin
      if (!ok) begin
        ok = (rxReady === 1'b1);
        @(posedge clk);
        #5;
      end
    end
    rxValid = 1'b0;
    rxByte = ~b;
  endtask
  task automatic plug(input logic v);
    vbusPin = v;
  endtask
  // Any data-line state change, as a resume would make
  task automatic wiggle();
    dataLineP = ~dataLineP;
    dataLineM = ~dataLineM;
  endtask
endmodule
`default_nettype wire

// *** test_usb_device_core_control.sv ***
// Self-checking bench for the USB device core control block
`timescale 1ns/1ns
`default_nettype none
module test_usb_device_core_control;
  localparam int NEP = ucc_pkg::NUM_EP;
  logic clk, clkEn, sys_rst, usbEndReset, cpuResetOnEor, macroEnable;
  logic freezeClockBit, lowSpeedSelect, pllSourceRc, pllLocked;
  logic wakeupFlagClr, vbusTransitionFlagClr, wakeupIntEn, vbusIntEn;
  logic [NEP-1:0] endpointEnableBit, memoryReserveBit, endpointBankCount;
  logic [NEP*3-1:0] endpointSizeField;
  logic [NEP*8-1:0] epFlagSet, epFlagClr, epFlagEn, epFlags;
  logic [7:0] rxByte, bufByte;
  logic rxValid, rxReady, bufValid, bufReady, stall;
  logic vbusPin, dataLineP, dataLineM;
  logic [1:0] ctrlState;
  logic controllerClkGate, transceiverEnable, padSuspend, pullUpDp;
  logic pullUpDm, speedFault, cpuResetReq, wakeupFlag, vbusTransitionFlag;
  logic vbusStatus, generalIrq, endpointIrq, bitClkTick;
  logic [NEP-1:0] endpointIntSummary, configAcceptedFlag, epDataLost;
  logic [NEP*10-1:0] epBase;
  logic [31:0] rnd;
  logic [7:0] expQ[$];
  int mismatches, nCompared, cycles, bitIdx, cnt;
  bit ok;
  ucc_core ucc_core_inst (.clk(clk), .clkEn(clkEn), .sys_rst(sys_rst),
    .usbEndReset(usbEndReset), .cpuResetOnEor(cpuResetOnEor),
    .macroEnable(macroEnable), .freezeClockBit(freezeClockBit),
    .lowSpeedSelect(lowSpeedSelect), .pllSourceRc(pllSourceRc),
    .pllLocked(pllLocked), .vbusPin(vbusPin), .dataLineP(dataLineP),
    .dataLineM(dataLineM), .wakeupFlagClr(wakeupFlagClr),
    .vbusTransitionFlagClr(vbusTransitionFlagClr),
    .wakeupIntEn(wakeupIntEn), .vbusIntEn(vbusIntEn),
    .endpointEnableBit(endpointEnableBit),
    .memoryReserveBit(memoryReserveBit),
    .endpointSizeField(endpointSizeField),
    .endpointBankCount(endpointBankCount), .epFlagSet(epFlagSet),
    .epFlagClr(epFlagClr), .epFlagEn(epFlagEn), .rxByte(rxByte),
    .rxValid(rxValid), .rxReady(rxReady), .bufByte(bufByte),
    .bufValid(bufValid), .bufReady(bufReady), .ctrlState(ctrlState),
    .controllerClkGate(controllerClkGate),
    .transceiverEnable(transceiverEnable), .padSuspend(padSuspend),
    .pullUpDp(pullUpDp), .pullUpDm(pullUpDm), .bitClkTick(bitClkTick),
    .speedFault(speedFault), .cpuResetReq(cpuResetReq),
    .wakeupFlag(wakeupFlag), .vbusTransitionFlag(vbusTransitionFlag),
    .vbusStatus(vbusStatus), .generalIrq(generalIrq),
    .endpointIrq(endpointIrq), .endpointIntSummary(endpointIntSummary),
    .epFlags(epFlags), .configAcceptedFlag(configAcceptedFlag),
    .epBase(epBase), .epDataLost(epDataLost));
  ucc_host_model ucc_host_model_inst (.clk(clk), .rxReady(rxReady),
    .stall(stall), .rxByte(rxByte), .rxValid(rxValid),
    .bufReady(bufReady), .vbusPin(vbusPin), .dataLineP(dataLineP),
    .dataLineM(dataLineM));
  // -----------------------------------------------------------
  // Clock, helpers and compare tasks
  // -----------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic checkBit(input string what, input logic e, input logic g);
    nCompared++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic check(input string what, input logic [15:0] e,
                       input logic [15:0] g);
    nCompared++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic pulse(ref logic sig);
    sig = 1'b1;
    step(1);
    sig = 1'b0;
    step(1);
  endtask
  task automatic pulseBit(ref logic [NEP*8-1:0] v, input int i);
    v[i] = 1'b1;
    step(1);
    v[i] = 1'b0;
    step(1);
  endtask
  // -----------------------------------------------------------
  // Stream watcher: takes the oldest note on each transfer
  // -----------------------------------------------------------
  always @(negedge clk) begin
    if (bufValid === 1'b1 && bufReady === 1'b1) begin
      nCompared++;
      if (expQ.size() == 0 || expQ[0] !== bufByte) begin
        mismatches++;
        $display("wrong value bufByte expected %h seen %h",
                 (expQ.size() != 0) ? expQ[0] : 8'hxx, bufByte);
      end
      if (expQ.size() != 0) void'(expQ.pop_front());
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      finish_test();
    end
  end
  // -----------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------
  initial begin
    {usbEndReset, cpuResetOnEor, macroEnable, lowSpeedSelect} = 4'h0;
    {pllSourceRc, pllLocked, wakeupFlagClr, vbusTransitionFlagClr} = 4'h0;
    {wakeupIntEn, vbusIntEn, stall} = 3'h0;
    {endpointEnableBit, memoryReserveBit, endpointBankCount} = '0;
    {endpointSizeField, epFlagSet, epFlagClr, epFlagEn} = '0;
    clkEn = 1'b1;
    freezeClockBit = 1'b1;
    sys_rst = 1'b1;
    rnd = 32'h6b216637;
    step(20);
    sys_rst = 1'b0;
    step(1);
    check("ctrlState", 16'(ucc_pkg::UCC_RESET), 16'(ctrlState));
    checkBit("padSuspend", 1'b1, padSuspend);
    checkBit("controllerClkGate", 1'b0, controllerClkGate);
    checkBit("transceiverEnable", 1'b0, transceiverEnable);
    $display("test reset state done");
    macroEnable = 1'b1;
    step(1);
    check("ctrlState", 16'(ucc_pkg::UCC_IDLE), 16'(ctrlState));
    freezeClockBit = 1'b0;
    pllLocked = 1'b1;
    step(1);
    check("ctrlState", 16'(ucc_pkg::UCC_RUN), 16'(ctrlState));
    checkBit("padSuspend", 1'b0, padSuspend);
    checkBit("controllerClkGate", 1'b1, controllerClkGate);
    ucc_host_model_inst.plug(1'b1);
    step(5);
    checkBit("vbusStatus", 1'b1, vbusStatus);
    checkBit("vbusTransitionFlag", 1'b1, vbusTransitionFlag);
    checkBit("generalIrq", 1'b0, generalIrq);
    pulse(vbusTransitionFlagClr);
    checkBit("vbusTransitionFlag", 1'b0, vbusTransitionFlag);
    pllSourceRc = 1'b1;
    for (int ls = 0; ls < 2; ls++) begin
      lowSpeedSelect = ls[0];
      step(1);
      checkBit("pullUpDm", ls[0], pullUpDm);
      checkBit("pullUpDp", ~ls[0], pullUpDp);
      checkBit("speedFault", ~ls[0], speedFault);
    end
    {pllSourceRc, lowSpeedSelect} = 2'b00;
    cnt = 0;
    repeat (8 * ucc_pkg::FS_DIV) begin
      if (bitClkTick === 1'b1) cnt++;
      step(1);
    end
    check("bitTicks", 16'd8, 16'(cnt));
    $display("test enable and speed done");
    for (int ep = 0; ep < NEP; ep++) begin
      rnd = lfsr(rnd);
      bitIdx = ep * 8 + int'(rnd[2:0]);
      epFlagEn[bitIdx] = 1'b1;
      pulseBit(epFlagSet, bitIdx);
      checkBit("epFlags", 1'b1, epFlags[bitIdx]);
      checkBit("endpointIrq", 1'b1, endpointIrq);
      checkBit("generalIrq", 1'b0, generalIrq);
      check("summary", 16'(1 << ep), 16'(endpointIntSummary));
      epFlagEn[bitIdx] = 1'b0;
      step(1);
      checkBit("endpointIrq", 1'b0, endpointIrq);
      pulseBit(epFlagClr, bitIdx);
      checkBit("epFlags", 1'b0, epFlags[bitIdx]);
    end
    $display("test endpoint interrupts done");
    endpointSizeField[11:0] = {3'd0, 3'd1, 3'd2, 3'd3};
    endpointBankCount[1] = 1'b1;
    for (int k = 0; k < 4; k++) begin
      endpointEnableBit[k] = 1'b1;
      memoryReserveBit[k] = 1'b1;
      step(2);
    end
    check("base1", 16'd64, 16'(epBase[19:10]));
    check("base2", 16'd128, 16'(epBase[29:20]));
    check("base3", 16'd144, 16'(epBase[39:30]));
    check("config_accepted_flag", 16'hf, 16'(configAcceptedFlag[3:0]));
    endpointEnableBit[1] = 1'b0;
    step(2);
    endpointEnableBit[1] = 1'b1;
    step(2);
    check("base2", 16'd128, 16'(epBase[29:20]));
    checkBit("lost2", 1'b0, epDataLost[2]);
    memoryReserveBit[1] = 1'b0;
    step(2);
    check("base2", 16'd64, 16'(epBase[29:20]));
    check("base3", 16'd144, 16'(epBase[39:30]));
    endpointSizeField[5:3] = 3'd3;
    step(1);
    memoryReserveBit[1] = 1'b1;
    step(2);
    check("base2", 16'd192, 16'(epBase[29:20]));
    check("base3", 16'd144, 16'(epBase[39:30]));
    check("config_accepted_flag", 16'hf, 16'(configAcceptedFlag[3:0]));
    checkBit("lost0", 1'b0, epDataLost[0]);
    $display("test buffer allocation done");
    stall = 1'b1;
    cnt = 0;
    ok = 1'b1;
    while (ok && cnt < 12) begin
      rnd = lfsr(rnd);
      ucc_host_model_inst.send(rnd[7:0], ok);
      if (ok) begin
        expQ.push_back(rnd[7:0]);
        cnt++;
      end
      step(1);
    end
    check("fifoFill", 16'(ucc_pkg::FIFO_DEPTH), 16'(cnt));
    stall = 1'b0;
    repeat (40) if (expQ.size() != 0) step(1);
    step(2);
    checkBit("bufValid", 1'b0, bufValid);
    check("leftover", 16'd0, 16'(expQ.size()));
    $display("test buffer fill and drain done");
    freezeClockBit = 1'b1;
    step(1);
    check("ctrlState", 16'(ucc_pkg::UCC_FROZEN), 16'(ctrlState));
    checkBit("controllerClkGate", 1'b0, controllerClkGate);
    epFlagEn[0] = 1'b1;
    pulseBit(epFlagSet, 0);
    checkBit("epFlags", 1'b0, epFlags[0]);
    checkBit("endpointIrq", 1'b0, endpointIrq);
    ucc_host_model_inst.send(8'h5a, ok);
    checkBit("rxTaken", 1'b0, ok);
    vbusIntEn = 1'b1;
    wakeupIntEn = 1'b1;
    ucc_host_model_inst.plug(1'b0);
    step(5);
    checkBit("vbusTransitionFlag", 1'b1, vbusTransitionFlag);
    checkBit("generalIrq", 1'b1, generalIrq);
    pulse(vbusTransitionFlagClr);
    checkBit("generalIrq", 1'b0, generalIrq);
    ucc_host_model_inst.wiggle();
    step(5);
    checkBit("wakeupFlag", 1'b1, wakeupFlag);
    checkBit("generalIrq", 1'b1, generalIrq);
    pulse(wakeupFlagClr);
    checkBit("wakeupFlag", 1'b0, wakeupFlag);
    freezeClockBit = 1'b0;
    step(1);
    check("ctrlState", 16'(ucc_pkg::UCC_RUN), 16'(ctrlState));
    $display("test freeze done");
    cpuResetOnEor = 1'b1;
    usbEndReset = 1'b1;
    #1;
    checkBit("cpuResetReq", 1'b1, cpuResetReq);
    step(1);
    usbEndReset = 1'b0;
    step(1);
    checkBit("transceiverEnable", 1'b1, transceiverEnable);
    macroEnable = 1'b0;
    step(1);
    check("ctrlState", 16'(ucc_pkg::UCC_RESET), 16'(ctrlState));
    checkBit("transceiverEnable", 1'b0, transceiverEnable);
    checkBit("controllerClkGate", 1'b0, controllerClkGate);
    checkBit("padSuspend", 1'b1, padSuspend);
    $display("test disable done");
    finish_test();
  end
endmodule
`default_nettype wire
